// file: src/adc_ctrl_defs.vh
// constants for the serial converter control block
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// widths
`define ADC_RES_BITS      10
`define ADC_ADDR_BITS     4

// channel map: codes 0..10 are external inputs, code 11 and up the self-test level
`define ADC_CHAN_COUNT    12
`define ADC_SELFTEST_ADDR 4'hb

// frame timing in link-clock edges
`define ADC_ADDR_EDGES    3'h4
`define ADC_OUT_SHIFTS    4'h9
`define ADC_START_EDGE    4'ha

// timing in system-clock cycles
`define ADC_GUARD_CYCLES  2'h3
`define ADC_CONV_CYCLES   6'h2c
`define ADC_STEP_CYCLES   4

// reset values and the first trial code loaded at conversion start
`define ADC_RESULT_RST    10'h000
`define ADC_ADDR_RST      4'h0
`define ADC_TRIAL_FIRST   10'h200

`endif

// file: src/sync_2ff.v
// two-flop synchroniser for one pin input
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst,
  input  wire asyncIn,
  output reg  syncOut
);

  reg meta_r;

  // first stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r  <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule // sync_2ff

`default_nettype wire

// file: src/serial_adc_channel_control.v
// serial link, channel select and successive-approximation sequencing
// Notes on behaviour
// - result is 10 bits by successive approximation
// - twelve channels: eleven inputs plus self-test
// - tenth falling link edge starts the conversion
// - conversion lasts 44 system clock periods
// - select low puts result MSB out at once
// - nine more bits out on falling edges
// - control inputs ignored three cycles after select
// - old result out while new address in
// - address bit sampled on rising link edge
// - over-range gives all ones, under-range zeros
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_defs.vh"

module serial_adc_channel_control (
  input  wire                        clk,
  input  wire                        rst,
  input  wire                        selectN,
  input  wire                        linkClk,
  input  wire                        addrIn,
  input  wire                        cmpHigh,
  output reg                         dataOut,
  output reg                         dataOeN,
  output reg  [`ADC_ADDR_BITS-1:0]   muxSel,
  output reg                         selfTestSel,
  output reg                         sampleEn,
  output reg  [`ADC_RES_BITS-1:0]    trialCode,
  output reg                         convBusy
);

  // frame states
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_GUARD  = 4'b0010;
  localparam [3:0] ST_ACTIVE = 4'b0100;
  localparam [3:0] ST_DONE   = 4'b1000;

  wire                       selS;
  wire                       clkS;
  wire                       addrS;
  reg                        selD_r;
  reg                        clkD_r;
  reg  [3:0]                 state_r;
  reg  [1:0]                 guardCnt_r;
  reg  [3:0]                 fallCnt_r;
  reg  [2:0]                 riseCnt_r;
  reg  [`ADC_ADDR_BITS-1:0]  addrShift_r;
  reg  [`ADC_ADDR_BITS-1:0]  addrLatch_r;
  reg  [`ADC_RES_BITS-1:0]   outShift_r;
  reg  [`ADC_RES_BITS-1:0]   result_r;
  reg  [`ADC_RES_BITS-1:0]   sarMask_r;
  reg  [5:0]                 convCnt_r;
  reg                        startConv_r;
  wire                       selFall;
  wire                       selRise;
  wire                       linkRise;
  wire                       linkFall;
  wire                       stepTick;
  wire [`ADC_ADDR_BITS-1:0]  addrNew;

  // select, link clock and address each cross two flops before any logic reads them
  sync_2ff #(.RST_VAL(1'b1)) u_syncSel (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (selectN),
    .syncOut (selS)
  );

  sync_2ff #(.RST_VAL(1'b0)) u_syncClk (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (linkClk),
    .syncOut (clkS)
  );

  sync_2ff #(.RST_VAL(1'b0)) u_syncAddr (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (addrIn),
    .syncOut (addrS)
  );

  // edge history of the synchronised pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      selD_r <= 1'b1;
      clkD_r <= 1'b0;
    end else begin
      selD_r <= selS;
      clkD_r <= clkS;
    end
  end

  assign selFall  = selD_r & ~selS;
  assign selRise  = ~selD_r & selS;
  assign linkRise = ~clkD_r & clkS;
  assign linkFall = clkD_r & ~clkS;
  assign addrNew  = {addrShift_r[`ADC_ADDR_BITS-2:0], addrS};

  // frame sequencer: guard, shift, then wait for select to rise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      guardCnt_r  <= 2'h0;
      fallCnt_r   <= 4'h0;
      riseCnt_r   <= 3'h0;
      addrShift_r <= `ADC_ADDR_RST;
      addrLatch_r <= `ADC_ADDR_RST;
      outShift_r  <= `ADC_RESULT_RST;
      dataOut     <= 1'b0;
      dataOeN     <= 1'b1;
      startConv_r <= 1'b0;
    end else begin
      startConv_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          dataOeN <= 1'b1;
          if (selFall) begin
            state_r    <= ST_GUARD;
            guardCnt_r <= 2'h0;
            fallCnt_r  <= 4'h0;
            riseCnt_r  <= 3'h0;
            outShift_r <= result_r;
            dataOut    <= result_r[`ADC_RES_BITS-1];
            dataOeN    <= 1'b0;
          end
        end
        ST_GUARD: begin
          if (selRise) begin
            state_r <= ST_IDLE;
            dataOeN <= 1'b1;
          end else if (guardCnt_r == `ADC_GUARD_CYCLES - 2'h1) begin
            state_r <= ST_ACTIVE;
          end else begin
            guardCnt_r <= guardCnt_r + 2'h1;
          end
        end
        ST_ACTIVE: begin
          if (selRise) begin
            state_r <= ST_IDLE;
            dataOeN <= 1'b1;
          end else begin
            if (linkRise && riseCnt_r < `ADC_ADDR_EDGES) begin
              addrShift_r <= addrNew;
              riseCnt_r   <= riseCnt_r + 3'h1;
              if (riseCnt_r == `ADC_ADDR_EDGES - 3'h1)
                addrLatch_r <= addrNew;
            end
            if (linkFall) begin
              fallCnt_r  <= fallCnt_r + 4'h1;
              dataOut    <= outShift_r[`ADC_RES_BITS-2];
              outShift_r <= {outShift_r[`ADC_RES_BITS-2:0], 1'b0};
              if (fallCnt_r == `ADC_START_EDGE - 4'h1) begin
                startConv_r <= 1'b1;
                state_r     <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          if (selRise) begin
            state_r <= ST_IDLE;
            dataOeN <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          dataOeN <= 1'b1;
        end
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      muxSel      <= `ADC_ADDR_RST;
      selfTestSel <= 1'b0;
      sampleEn    <= 1'b0;
    end else begin
      muxSel      <= addrLatch_r;
      // codes past the last external input fall back to self-test
      selfTestSel <= (addrLatch_r >= `ADC_SELFTEST_ADDR);
      // track the input from the address latch until the hold at start
      if (startConv_r && !convBusy)
        sampleEn <= 1'b0;
      else if (state_r == ST_ACTIVE && riseCnt_r == `ADC_ADDR_EDGES)
        sampleEn <= 1'b1;
    end
  end

  // one approximation step every few cycles, last one well before the end
  assign stepTick = convBusy &&
                    (convCnt_r[1:0] == 2'h3) &&
                    (sarMask_r != {`ADC_RES_BITS{1'b0}});

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      convBusy  <= 1'b0;
      convCnt_r <= 6'h00;
      sarMask_r <= {`ADC_RES_BITS{1'b0}};
      trialCode <= `ADC_RESULT_RST;
      result_r  <= `ADC_RESULT_RST;
    end else if (!convBusy) begin
      // a start during a running conversion cannot happen here: busy gates it
      if (startConv_r) begin
        convBusy  <= 1'b1;
        convCnt_r <= 6'h00;
        sarMask_r <= `ADC_TRIAL_FIRST;
        trialCode <= `ADC_TRIAL_FIRST;
      end
    end else begin
      convCnt_r <= convCnt_r + 6'h01;
      if (stepTick) begin
        trialCode <= (cmpHigh ? trialCode : (trialCode & ~sarMask_r)) |
                     (sarMask_r >> 1);
        sarMask_r <= sarMask_r >> 1;
      end
      if (convCnt_r == `ADC_CONV_CYCLES - 6'h01) begin
        convBusy <= 1'b0;
        result_r <= trialCode;
      end
    end
  end

endmodule // serial_adc_channel_control

`default_nettype wire

// file: verif/adc_host_model.sv
// host side of the serial link: drives select, shift clock and address
`timescale 1ns/1ns
`default_nettype none
module adc_host_model (
  input  wire logic clk,
  input  wire logic dataOut,
  input  wire logic dataOeN,
  output var  logic selectN,
  output var  logic linkClk,
  output var  logic addrIn
);
  // a released pin floats, so a late read shows up as z
  wire dataPin = dataOeN ? 1'bz : dataOut;
  initial begin
    selectN = 1'b1;
    linkClk = 1'b0;
    addrIn  = 1'b0;
  end
  // one frame: old result comes out while the next address goes in
  // glitch puts a one-cycle link pulse inside the select guard, which must be ignored
  task automatic frame(input logic [3:0] addr, input logic glitch, output logic [9:0] got);
    integer i;
    @(negedge clk) selectN = 1'b0;
    if (glitch) begin
      // pulse lands while the guard still runs
      @(negedge clk) linkClk = 1'b1;
      @(negedge clk) linkClk = 1'b0;
      repeat (6) @(negedge clk);
    end else begin
      repeat (8) @(negedge clk);
    end
    for (i = 0; i < 10; i++) begin
      addrIn = (i < 4) ? addr[3 - i] : 1'b0;
      repeat (4) @(negedge clk);
      linkClk = 1'b1;
      repeat (4) @(negedge clk);
      got[9 - i] = dataPin; // read just before the falling edge
      linkClk = 1'b0;
    end
    repeat (60) @(negedge clk);
    selectN = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // adc_host_model
`default_nettype wire

// file: verif/serial_adc_channel_control_asserts.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ns
`default_nettype none
module serial_adc_channel_control_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       selectN,
  input wire logic       dataOut,
  input wire logic       dataOeN,
  input wire logic [3:0] muxSel,
  input wire logic       selfTestSel,
  input wire logic       sampleEn,
  input wire logic [9:0] trialCode,
  input wire logic       convBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // cycles spent busy, so the conversion length can be judged exactly
  logic [6:0] busyCnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busyCnt_r <= 7'h00;
    else busyCnt_r <= convBusy ? busyCnt_r + 7'h01 : 7'h00;
  end
  a_idle_released: assert property (selectN [*6] |-> dataOeN)
    else $error("data output driven while deselected");
  a_msb_on_select: assert property ($fell(selectN) |-> ##[3:5] !dataOeN)
    else $error("data output not driven after select fell");
  a_guard_quiet: assert property ($fell(dataOeN) |=> $stable(dataOut) [*3])
    else $error("data output moved inside the select guard");
  a_conv_length: assert property ($fell(convBusy) |-> busyCnt_r == 7'h2c)
    else $error("conversion length wrong");
  a_conv_start: assert property ($rose(convBusy) |-> trialCode == 10'h200 && !sampleEn)
    else $error("conversion did not start from the midpoint in hold");
  a_addr_held: assert property (convBusy && $past(convBusy) |-> $stable(muxSel))
    else $error("channel changed during conversion");
  a_selftest_map: assert property ($stable(muxSel) [*2] |-> selfTestSel == (muxSel >= 4'hb))
    else $error("self-test select does not follow the channel code");
  a_code_kept: assert property (!convBusy && !$past(convBusy) |-> $stable(trialCode))
    else $error("result code moved while idle");
  cover property ($fell(convBusy));
  cover property ($rose(selfTestSel));
  cover property ($fell(dataOeN));
endmodule // serial_adc_channel_control_asserts
bind serial_adc_channel_control serial_adc_channel_control_asserts i_serial_adc_channel_control_asserts (
  .clk(clk), .rst(rst), .selectN(selectN), .dataOut(dataOut), .dataOeN(dataOeN),
  .muxSel(muxSel), .selfTestSel(selfTestSel), .sampleEn(sampleEn),
  .trialCode(trialCode), .convBusy(convBusy));
`default_nettype wire

// file: verif/serial_adc_channel_control_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module serial_adc_channel_control_tb;
  logic       clk, rst, selectN, linkClk, addrIn, cmpHigh, dataOut, dataOeN;
  logic       selfTestSel, sampleEn, convBusy;
  logic [3:0] muxSel;
  logic [9:0] trialCode, vin;
  integer     errors, checked;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // analog stand-in: comparator weighs the input against the trial code
  always @(negedge clk) cmpHigh <= (vin >= trialCode);
  serial_adc_channel_control i_serial_adc_channel_control (
    .clk(clk), .rst(rst), .selectN(selectN), .linkClk(linkClk), .addrIn(addrIn),
    .cmpHigh(cmpHigh), .dataOut(dataOut), .dataOeN(dataOeN), .muxSel(muxSel),
    .selfTestSel(selfTestSel), .sampleEn(sampleEn), .trialCode(trialCode),
    .convBusy(convBusy));
  adc_host_model i_adc_host_model (.clk(clk), .dataOut(dataOut), .dataOeN(dataOeN),
    .selectN(selectN), .linkClk(linkClk), .addrIn(addrIn));
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reset leaves the pin released and nothing converting
  task automatic t_reset;
    check("dataOeN", 10'h001, {9'h000, dataOeN});
    check("convBusy", 10'h000, {9'h000, convBusy});
    check("sampleEn", 10'h000, {9'h000, sampleEn});
    check("trialCode", 10'h000, trialCode);
    check("muxSel", 10'h000, {6'h00, muxSel});
  endtask
  // every address code: mux, self-test flag, and the result of the frame before;
  // odd codes also carry a link pulse inside the guard, which must change nothing
  task automatic t_sweep;
    logic [9:0] got;
    logic [9:0] prev;
    integer a;
    prev = 10'h000;
    for (a = 0; a < 16; a++) begin
      vin = {a[3:0], a[3:0], 2'h1};
      i_adc_host_model.frame(a[3:0], a[0], got);
      check("result", prev, got);
      check("trialCode", vin, trialCode);
      check("muxSel", {6'h00, a[3:0]}, {6'h00, muxSel});
      check("selfTestSel", {9'h000, a >= 11}, {9'h000, selfTestSel});
      check("sampleEn", 10'h000, {9'h000, sampleEn});
      check("dataOeN", 10'h001, {9'h000, dataOeN});
      prev = vin;
    end
  endtask
  // extreme inputs give all ones, then all zeros
  task automatic t_extremes;
    logic [9:0] got;
    vin = 10'h3ff;
    i_adc_host_model.frame(4'h3, 1'b0, got);
    check("last sweep result", 10'h3fd, got);
    vin = 10'h000;
    i_adc_host_model.frame(4'h3, 1'b0, got);
    check("full scale", 10'h3ff, got);
    i_adc_host_model.frame(4'h3, 1'b0, got);
    check("zero scale", 10'h000, got);
    check("muxSel", 10'h003, {6'h00, muxSel});
  endtask
  initial begin
    errors = 0;
    checked = 0;
    vin = 10'h000;
    cmpHigh = 1'b0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    t_reset();
    t_sweep();
    t_extremes();
    print_verdict();
  end
  // watchdog: some twenty frames of about 157 cycles each fit well inside
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule // serial_adc_channel_control_tb
`default_nettype wire
